// file: rtl/cmt_defs.svh
// constants for the compare match timer: offsets, fields, resets, timing
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH
// register indices as printed; byte address is four times the index
`define CMT_IDX_COUNT 12'h118
`define CMT_IDX_COMPARE 12'h119
`define CMT_IDX_CTRL1 12'h11C
`define CMT_IDX_IRQEN 12'h11D
`define CMT_IDX_SRCSEL 12'h11E
`define CMT_IDX_BUSY 12'h11F
// control_one fields
`define CMT_C1_STATUS 1
`define CMT_C1_OE 2
`define CMT_C1_TIMING 3
`define CMT_C1_SRST 4
`define CMT_C1_PM 5
`define CMT_C1_H24 6
`define CMT_C1_START 7
`define CMT_C1_WMASK 8'hFC
// interrupt_enable_ctrl fields
`define CMT_IE_MATCH 5
`define CMT_IE_WMASK 8'h3F
// source_select fields
`define CMT_SS_PRE 2
`define CMT_SS_WMASK 8'h7F
`define CMT_RESET8 8'h00
`define CMT_RESET4 4'h0
// output select codes
`define CMT_OS_F2 3'h0
`define CMT_OS_SUB 3'h1
`define CMT_OS_F4 3'h2
`define CMT_OS_F8 3'h4
`define CMT_OS_CMP 3'h6
// source select codes
`define CMT_SRC_F4 2'h0
`define CMT_SRC_F8 2'h1
`define CMT_SRC_F32 2'h2
`define CMT_SRC_SUB4 2'h3
// busy flag duration in microseconds, clock period in nanoseconds
`define CMT_BUSY_US 62500
`define CMT_CLK_NS 40
`define CMT_BUSY_CYC ((`CMT_BUSY_US * 1000) / `CMT_CLK_NS)
`define CMT_TRANS_NONSEQ 2'h2
`endif

// file: rtl/cmt_pkg.sv
// types for the compare match timer
package cmt_pkg;
    typedef enum logic [1:0] {
        CMT_RUN_IDLE = 2'b01,
        CMT_RUN_ON = 2'b10
    } cmt_run_t;
endpackage

// file: rtl/cmt_timer.sv
// compare match timer with AHB-Lite register slave
`timescale 1ns/100ps
// Summary of operation
// - count register reads live 8-bit counter
// - counter holds its value while stopped
// - match clears counter, counting continues
// - compare register read/write, match target
// - status bit shows counting state
// - output enable gates signal onto pin
// - soft reset 1 then 0 clears timer
// - match interrupt enable gates request
// - pre-counter select inserts 4-bit stage
// - output select routes clock or compare
// - start sets status within two source cycles
// - stop clears status within two source cycles
// - stopped means start and status both zero
// - calendar busy flag lasts about 62.5 ms
// - counter advances every 2 or 32 source cycles
// - compare output toggles, low after reset
// - interrupt on counter equal compare
// - count writes ignored, compare when running
`include "cmt_defs.svh"
module cmt_timer #(
    parameter int BUSY_CYCLES = `CMT_BUSY_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic subclk,
    output logic timer_output_pin,
    output logic match_irq
);
    if (BUSY_CYCLES < 1) begin : g_busy_check
        $error("BUSY_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic wr_q;
    logic [11:0] idx_q;
    logic ap_valid;
    assign ap_valid = hsel && hready && htrans == `CMT_TRANS_NONSEQ;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            idx_q <= 12'h000;
        end else begin
            wr_q <= ap_valid && hwrite;
            idx_q <= haddr[13:2];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] count_q;
    logic [7:0] compare_value_q;
    logic [7:0] control_one_q;
    logic [7:0] interrupt_enable_ctrl_q;
    logic [7:0] source_select_q;
    logic status_q;
    logic srst_clear;
    logic stopped;
    logic [7:0] wbyte;
    assign wbyte = hwdata[7:0];
    assign stopped = !control_one_q[`CMT_C1_START] && !status_q;
    // clear fires on the falling write of the soft reset bit
    assign srst_clear = wr_q && idx_q == `CMT_IDX_CTRL1
        && control_one_q[`CMT_C1_SRST] && !wbyte[`CMT_C1_SRST];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_value_q <= `CMT_RESET8;
        end else if (srst_clear) begin
            compare_value_q <= `CMT_RESET8;
        end else if (wr_q && idx_q == `CMT_IDX_COMPARE && stopped) begin
            compare_value_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_one_q <= `CMT_RESET8;
        end else if (srst_clear) begin
            // output enable survives; srst bit itself takes the 0 written
            control_one_q <= control_one_q & (8'h01 << `CMT_C1_OE);
        end else if (wr_q && idx_q == `CMT_IDX_CTRL1) begin
            control_one_q <= wbyte & `CMT_C1_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_enable_ctrl_q <= `CMT_RESET8;
        end else if (srst_clear) begin
            interrupt_enable_ctrl_q <= `CMT_RESET8;
        end else if (wr_q && idx_q == `CMT_IDX_IRQEN) begin
            interrupt_enable_ctrl_q <= wbyte & `CMT_IE_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            source_select_q <= `CMT_RESET8;
        end else if (wr_q && idx_q == `CMT_IDX_SRCSEL) begin
            source_select_q <= wbyte & `CMT_SS_WMASK;
        end
    end

    // ------------------------------------------------------------
    // sub-clock synchroniser and source rate enables
    // ------------------------------------------------------------
    logic [2:0] sub_sync_q;
    logic sub_level_q;
    logic sub_rise;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_sync_q <= 3'h0;
            sub_level_q <= 1'b0;
        end else begin
            sub_sync_q <= {sub_sync_q[1:0], subclk};
            if (sub_sync_q[1] == sub_sync_q[2]) begin
                sub_level_q <= sub_sync_q[2];
            end
        end
    end
    assign sub_rise = sub_sync_q[1] == sub_sync_q[2]
        && sub_sync_q[2] && !sub_level_q;

    // free divider of hclk gives f2..f32; sub edges counted for sub/4
    logic [4:0] div_q;
    logic [1:0] sub_div_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 5'h00;
            sub_div_q <= 2'h0;
        end else begin
            div_q <= div_q + 5'h01;
            if (sub_rise) begin
                sub_div_q <= sub_div_q + 2'h1;
            end
        end
    end

    logic src_tick;
    always_comb begin
        unique case (source_select_q[1:0])
            `CMT_SRC_F4: src_tick = div_q[1:0] == 2'h3;
            `CMT_SRC_F8: src_tick = div_q[2:0] == 3'h7;
            `CMT_SRC_F32: src_tick = div_q == 5'h1F;
            `CMT_SRC_SUB4: src_tick = sub_rise && sub_div_q == 2'h3;
        endcase
    end

    // ------------------------------------------------------------
    // start/stop handshake on source ticks
    // ------------------------------------------------------------
    // one domain, so the start bit is sampled on the source enable;
    // status follows on the next tick, at most two source cycles after the write
    cmt_pkg::cmt_run_t run_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= cmt_pkg::CMT_RUN_IDLE;
            status_q <= 1'b0;
        end else if (srst_clear) begin
            run_q <= cmt_pkg::CMT_RUN_IDLE;
            status_q <= 1'b0;
        end else if (src_tick) begin
            unique case (run_q)
                cmt_pkg::CMT_RUN_IDLE: begin
                    if (control_one_q[`CMT_C1_START]) begin
                        run_q <= cmt_pkg::CMT_RUN_ON;
                    end
                end
                cmt_pkg::CMT_RUN_ON: begin
                    if (!control_one_q[`CMT_C1_START]) begin
                        run_q <= cmt_pkg::CMT_RUN_IDLE;
                    end
                end
            endcase
            status_q <= run_q == cmt_pkg::CMT_RUN_ON;
        end
    end

    // ------------------------------------------------------------
    // counters, match, compare output
    // ------------------------------------------------------------
    logic half_q;
    logic [3:0] pre_q;
    logic step;
    logic match;
    logic cmp_out_q;
    logic adv;
    assign adv = src_tick && status_q && run_q == cmt_pkg::CMT_RUN_ON;
    // divide by two always; the pre-counter adds a further sixteen
    assign step = adv && half_q
        && (!source_select_q[`CMT_SS_PRE] || pre_q == 4'hF);
    assign match = step && count_q == compare_value_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_q <= 1'b0;
            pre_q <= `CMT_RESET4;
            count_q <= `CMT_RESET8;
        end else if (srst_clear) begin
            half_q <= 1'b0;
            pre_q <= `CMT_RESET4;
            count_q <= `CMT_RESET8;
        end else if (adv) begin
            half_q <= !half_q;
            if (half_q && source_select_q[`CMT_SS_PRE]) begin
                pre_q <= pre_q + 4'h1;
            end
            if (match) begin
                count_q <= `CMT_RESET8;
            end else if (step) begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_out_q <= 1'b0;
            match_irq <= 1'b0;
        end else if (srst_clear) begin
            cmp_out_q <= 1'b0;
            match_irq <= 1'b0;
        end else begin
            if (match) begin
                cmp_out_q <= !cmp_out_q;
            end
            match_irq <= match
                && interrupt_enable_ctrl_q[`CMT_IE_MATCH];
        end
    end

    // ------------------------------------------------------------
    // output pin mux
    // ------------------------------------------------------------
    logic pin_sel;
    always_comb begin
        unique case (source_select_q[6:4])
            `CMT_OS_F2: pin_sel = div_q[0];
            `CMT_OS_SUB: pin_sel = sub_level_q;
            `CMT_OS_F4: pin_sel = div_q[1];
            `CMT_OS_F8: pin_sel = div_q[2];
            `CMT_OS_CMP: pin_sel = cmp_out_q;
            default: pin_sel = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_output_pin <= 1'b0;
        end else begin
            timer_output_pin <= control_one_q[`CMT_C1_OE]
                && pin_sel;
        end
    end

    // ------------------------------------------------------------
    // calendar busy flag: timed pulse after each calendar second tick
    // ------------------------------------------------------------
    logic [31:0] busy_cnt_q;
    logic busy_q;
    logic cal_mode;
    assign cal_mode = source_select_q[3];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_cnt_q <= 32'h0;
            busy_q <= 1'b0;
        end else if (!cal_mode || srst_clear) begin
            busy_cnt_q <= 32'h0;
            busy_q <= 1'b0;
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
            if (busy_cnt_q == 32'(BUSY_CYCLES - 1)) begin
                busy_q <= 1'b0;
            end
        end else if (adv && half_q) begin
            busy_q <= 1'b1;
            busy_cnt_q <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (ap_valid && !hwrite) begin
            unique case (haddr[13:2])
                `CMT_IDX_COUNT: hrdata <= {24'h0, count_q};
                `CMT_IDX_COMPARE: hrdata <= {24'h0, compare_value_q};
                `CMT_IDX_CTRL1: hrdata <= {24'h0, control_one_q[7:2],
                    status_q, 1'b0};
                `CMT_IDX_IRQEN: hrdata <= {24'h0, interrupt_enable_ctrl_q};
                `CMT_IDX_SRCSEL: hrdata <= {24'h0, source_select_q};
                `CMT_IDX_BUSY: hrdata <= {31'h0, busy_q};
                default: hrdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule // cmt_timer

// file: test/cmt_timer_monitor.sv
// port-level assertions for the compare match timer
`timescale 1ns/100ps
`include "cmt_defs.svh"
module cmt_timer_monitor #(
    parameter int BUSY_CYCLES = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic timer_output_pin,
    input wire logic match_irq
);
    logic rd_bad_q;
    logic ie_wr_q;
    logic ie_q;
    wire take = hsel && hready && htrans == `CMT_TRANS_NONSEQ;
    wire [11:0] idx = haddr[13:2];
    wire mapped = idx inside {[`CMT_IDX_COUNT:`CMT_IDX_COMPARE],
        [`CMT_IDX_CTRL1:`CMT_IDX_BUSY]};
    // soft reset is not tracked, so the enable shadow can only be lenient
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_bad_q <= 1'h0;
            ie_wr_q <= 1'h0;
            ie_q <= 1'h0;
        end else begin
            rd_bad_q <= take && !hwrite && !mapped;
            ie_wr_q <= take && hwrite && idx == `CMT_IDX_IRQEN;
            if (ie_wr_q) begin
                ie_q <= hwdata[`CMT_IE_MATCH];
            end
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence quiet_s;
        !match_irq [*7];
    endsequence
    ready_always_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp)
        else $error("error response");
    irq_spacing_a: assert property (match_irq |=> quiet_s)
        else $error("match pulses too close");
    irq_gated_a: assert property (
        match_irq |-> ie_q || $past(ie_q))
        else $error("match pulse while disabled");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rdata_holds_a: assert property (
        !$past(take && !hwrite) |-> $stable(hrdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_bad_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    pin_reset_a: assert property ($rose(hresetn) |-> !timer_output_pin)
        else $error("pin high after reset");
endmodule // cmt_timer_monitor
bind cmt_timer cmt_timer_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_output_pin(timer_output_pin), .match_irq(match_irq));

// file: test/cmt_timer_test.sv
// self-checking bench for the compare match timer
`timescale 1ns/100ps
`include "cmt_defs.svh"
module cmt_timer_test;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic subclk = 1'h0;
    logic rd_ph = 1'h0;
    logic pin_q = 1'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic pin;
    logic irq;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int n_fail = 0;
    int checks_done = 0;
    int n_irq = 0;
    int n_pin = 0;
    int cyc = 0;
    cmt_timer #(.BUSY_CYCLES(8)) u_cmt_timer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .subclk(subclk), .timer_output_pin(pin),
        .match_irq(irq));
    initial begin
        forever #20 hclk = ~hclk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic ok);
        checks_done++;
        if (ok !== 1'h1) begin
            n_fail++;
            $display("BAD at %0t: result differs", $time);
        end
    endtask
    // ------------------------------------------------------------
    // bus master: hold each phase until hready is seen high
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] i,
                        input logic [7:0] d);
        hsel <= 1'h1;
        htrans <= `CMT_TRANS_NONSEQ;
        hwrite <= w;
        haddr <= {18'h0, i, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rd_ph <= !w;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd_ph <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] i, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        xfer(1'h0, i, 8'h0);
    endtask
    // sub-clock of 8 hclk periods, pin edge and pulse counts, read checks
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        pin_q <= pin;
        if (cyc % 4 == 3) subclk <= ~subclk;
        if (irq === 1'h1) n_irq <= n_irq + 1;
        if (pin !== pin_q) n_pin <= n_pin + 1;
        if (rd_ph && hreadyout === 1'h1)
            chk((hrdata & msk_q.pop_front()) === exp_q.pop_front());
        if (cyc > 60000) begin
            n_fail++;
            finish_test();
        end
    end
    // per: hclk cycles per counter step (two source ticks, 32 with the pre-counter)
    task automatic run_cfg(input logic [1:0] s, input logic p, ie,
                           input int per);
        int n;
        int a;
        int b;
        n = $urandom % 4;
        // soft reset first: a count left above the new compare would wrap
        xfer(1'h1, `CMT_IDX_CTRL1, 8'h10);
        xfer(1'h1, `CMT_IDX_CTRL1, 8'h00);
        xfer(1'h1, `CMT_IDX_COMPARE, n[7:0]);
        xfer(1'h1, `CMT_IDX_SRCSEL,
             {1'h0, `CMT_OS_CMP, 1'h0, p, s});
        xfer(1'h1, `CMT_IDX_IRQEN, {2'h0, ie, 5'h0});
        xfer(1'h1, `CMT_IDX_CTRL1, 8'h84);
        repeat (per + 8) @(posedge hclk);
        rd(`CMT_IDX_CTRL1, 32'h86, 32'hFF);
        xfer(1'h1, `CMT_IDX_COMPARE, 8'hFF);
        a = n_irq;
        b = n_pin;
        repeat (per * (n + 1) * 10) @(posedge hclk);
        chk(n_pin - b inside {[9:11]});
        a = ie ? n_irq - a - n_pin + b : n_irq - a;
        chk(ie ? a inside {[-1:1]} : a == 0);
        xfer(1'h1, `CMT_IDX_CTRL1, 8'h04);
        repeat (per + 8) @(posedge hclk);
        rd(`CMT_IDX_CTRL1, 32'h04, 32'hFF);
        rd(`CMT_IDX_COMPARE, n, 32'hFF);
        rd(`CMT_IDX_COUNT, 32'h0, 32'hFC);
        a = n_pin;
        repeat (100) @(posedge hclk);
        chk(n_pin == a);
    endtask
    int os_t[5] = '{0, 1, 2, 4, 0};
    int eg_t[5] = '{64, 16, 32, 16, 0};
    logic [11:0] ix_t[7] = '{12'h118, 12'h119, 12'h11C, 12'h11D,
        12'h11E, 12'h11F, 12'h120};
    initial begin
        int b;
        void'($urandom(94757));
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        foreach (ix_t[i]) rd(ix_t[i], 32'h0, 32'hFFFFFFFF);
        xfer(1'h1, `CMT_IDX_COMPARE, 8'hA5);
        rd(`CMT_IDX_COMPARE, 32'hA5, 32'hFF);
        xfer(1'h1, `CMT_IDX_COUNT, 8'h55);
        rd(`CMT_IDX_COUNT, 32'h0, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            xfer(1'h1, `CMT_IDX_CTRL1, 8'h00);
            xfer(1'h1, `CMT_IDX_SRCSEL, {1'h0, os_t[i][2:0], 4'h0});
            xfer(1'h1, `CMT_IDX_CTRL1, {5'h0, i < 4, 2'h0});
            b = n_pin;
            repeat (64) @(posedge hclk);
            chk(n_pin - b inside {[eg_t[i] - 2:eg_t[i] + 2]});
        end
        run_cfg(`CMT_SRC_F4, 1'h0, 1'h1, 8);
        run_cfg(`CMT_SRC_F8, 1'h0, 1'h1, 16);
        run_cfg(`CMT_SRC_F32, 1'h0, 1'h1, 64);
        run_cfg(`CMT_SRC_SUB4, 1'h0, 1'h1, 64);
        run_cfg(`CMT_SRC_F4, 1'h1, 1'h0, 128);
        xfer(1'h1, `CMT_IDX_COMPARE, 8'h02);
        xfer(1'h1, `CMT_IDX_IRQEN, 8'h20);
        xfer(1'h1, `CMT_IDX_CTRL1, 8'h14);
        xfer(1'h1, `CMT_IDX_CTRL1, 8'h04);
        rd(`CMT_IDX_COMPARE, 32'h0, 32'hFF);
        rd(`CMT_IDX_IRQEN, 32'h0, 32'hFF);
        rd(`CMT_IDX_CTRL1, 32'h04, 32'hFF);
        rd(`CMT_IDX_COUNT, 32'h0, 32'hFF);
        chk(pin === 1'h0);
        // let the watcher take the last read before the verdict
        repeat (2) @(posedge hclk);
        chk(exp_q.size() == 0);
        finish_test();
    end
endmodule // cmt_timer_test
